// ### core/mch_pkg.sv
// Package for the modem-control handshake block: map, fields, states.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package mch_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_WAIT = 8'h04;
    localparam logic [7:0] ADDR_RTSOFF = 8'h08;
    localparam logic [7:0] ADDR_LINE = 8'h0c;
    localparam logic [7:0] ADDR_ERR = 8'h10;
    localparam logic [7:0] ADDR_DIAG = 8'h14;
    // Control fields
    localparam int CTRL_AUTO = 0;
    localparam int CTRL_DTR = 1;
    localparam int CTRL_RTS = 2;
    // Error fields, write one to clear
    localparam int ERR_DTR_OFF = 0;
    localparam int ERR_CTS_TMO = 1;
    localparam int ERR_CTS_DROP = 2;
    localparam int ERR_DSR_DROP = 3;
    localparam int ERR_W = 4;
    // Widths and reset values
    localparam int TMR_W = 16;
    localparam logic [TMR_W-1:0] WAIT_RST = 16'h0100;
    localparam logic [TMR_W-1:0] RTSOFF_RST = 16'h0100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Sampled partner lines
    typedef struct packed {
        logic dcd;
        logic dsr;
        logic cts;
        logic ri;
    } mch_line_in_s;
    // Transmit handshake states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT = 4'h2,
        ST_SEND = 4'h4,
        ST_HOLD = 4'h8
    } mch_state_e;
endpackage

// ### core/mch_top.sv
// Modem-control handshake: DTR/RTS drive, DCD/DSR/CTS/RI sampling,
// automatic RTS/CTS send gating and DSR/DTR receive gating.
// Assumes AXI4-Lite master on aclk; partner lines are asynchronous.
// Contract
// R01 - After reset both DTR and RTS are OFF.
// R02 - Entering automatic mode drives RTS OFF and DTR ON at once.
// R03 - No frame moves while DTR is OFF; incoming data ignored then.
// R04 - Send request while DTR OFF is aborted with an error.
// R05 - Accepted send request raises RTS and loads the waiting timer.
// R06 - Sending starts only after waiting timer expiry with CTS ON.
// R07 - CTS not ON by waiting-time end aborts send with error.
// R08 - CTS falling during sending aborts it with error.
// R09 - After last character RTS stays ON for time-to-RTS-OFF, then OFF.
// R10 - RTS release never waits for CTS to fall.
// R11 - Reception enabled only while DSR is ON.
// R12 - Receive buffer near overflow changes no handshake line.
// R13 - DSR falling aborts send or receive, errors, logs diagnostic event.
// R14 - Automatic mode ignores software RTS/DTR and disables flow control.
// R15 - All six line levels readable in every mode.
// R16 - Partner answers RTS with CTS when able to accept data.
// R17 - Time-to-RTS-OFF is a software setting long enough for partner.
// R18 - Waiting time is a software setting long enough for partner.
// R19 - Intervals count clock ticks, reload per request, abort drops RTS.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module mch_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Partner lines
    input wire mch_pkg::mch_line_in_s line_in,
    output logic dtr_out,
    output logic rts_out,
    // Transmitter side
    input wire logic tx_req,
    input wire logic tx_last_done,
    output logic tx_grant,
    output logic tx_fail,
    // Receiver side
    input wire logic rx_near_full,
    output logic rx_enable,
    output logic rx_abort
);
    mch_pkg::mch_line_in_s sync1_ff, sync2_ff;
    logic dsr_q_ff, auto_q_ff;
    logic [2:0] ctrl_ff;
    logic [mch_pkg::TMR_W-1:0] wait_cfg_ff, rtsoff_cfg_ff, tmr_ff;
    logic [mch_pkg::ERR_W-1:0] err_ff, err_set;
    logic [15:0] diag_cnt_ff;
    mch_pkg::mch_state_e state_ff;
    logic aw_hold_ff, w_hold_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic auto_mode, dsr_fall, cts_on, do_write;

    // Map check shared by read and write paths
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == mch_pkg::ADDR_CTRL) || (a == mch_pkg::ADDR_WAIT) ||
            (a == mch_pkg::ADDR_RTSOFF) || (a == mch_pkg::ADDR_LINE) ||
            (a == mch_pkg::ADDR_ERR) || (a == mch_pkg::ADDR_DIAG);
    endfunction

    // Two-stage synchroniser for the asynchronous partner lines
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            dsr_q_ff <= 1'b0;
        end else begin
            sync1_ff <= line_in;
            sync2_ff <= sync1_ff;
            dsr_q_ff <= sync2_ff.dsr;
        end
    end

    assign auto_mode = ctrl_ff[mch_pkg::CTRL_AUTO];
    assign dsr_fall = dsr_q_ff && !sync2_ff.dsr;
    assign cts_on = sync2_ff.cts;
    assign do_write = aw_hold_ff && w_hold_ff && !s_bvalid;

    // Write channel: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            w_hold_ff <= 1'b0;
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= mch_pkg::RESP_OKAY;
            awaddr_ff <= '0;
            wdata_ff <= '0;
            wstrb_ff <= '0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_hold_ff <= 1'b1;
                s_awready <= 1'b0;
                awaddr_ff <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_ff <= 1'b1;
                s_wready <= 1'b0;
                wdata_ff <= s_wdata;
                wstrb_ff <= s_wstrb;
            end
            if (do_write) begin
                s_bvalid <= 1'b1;
                s_bresp <= addr_ok(awaddr_ff) ? mch_pkg::RESP_OKAY : mch_pkg::RESP_DECERR;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                aw_hold_ff <= 1'b0;
                w_hold_ff <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // Configuration registers; only byte lane 0 and 1 carry bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff <= '0;
            wait_cfg_ff <= mch_pkg::WAIT_RST;
            rtsoff_cfg_ff <= mch_pkg::RTSOFF_RST;
        end else if (do_write) begin
            if (awaddr_ff == mch_pkg::ADDR_CTRL && wstrb_ff[0])
                ctrl_ff <= wdata_ff[2:0];
            if (awaddr_ff == mch_pkg::ADDR_WAIT) begin // R18
                if (wstrb_ff[0]) wait_cfg_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) wait_cfg_ff[15:8] <= wdata_ff[15:8];
            end
            if (awaddr_ff == mch_pkg::ADDR_RTSOFF) begin // R17
                if (wstrb_ff[0]) rtsoff_cfg_ff[7:0] <= wdata_ff[7:0];
                if (wstrb_ff[1]) rtsoff_cfg_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // Read channel, one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= mch_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= addr_ok(s_araddr) ? mch_pkg::RESP_OKAY : mch_pkg::RESP_DECERR;
            case (s_araddr)
                mch_pkg::ADDR_CTRL: s_rdata <= {29'h0, ctrl_ff};
                mch_pkg::ADDR_WAIT: s_rdata <= {16'h0, wait_cfg_ff};
                mch_pkg::ADDR_RTSOFF: s_rdata <= {16'h0, rtsoff_cfg_ff};
                // Six line levels plus state, readable in any mode
                mch_pkg::ADDR_LINE: s_rdata <= {20'h0, state_ff, 2'h0, sync2_ff.ri, // R15
                    sync2_ff.cts, rts_out, sync2_ff.dsr, dtr_out, sync2_ff.dcd};
                mch_pkg::ADDR_ERR: s_rdata <= {28'h0, err_ff};
                mch_pkg::ADDR_DIAG: s_rdata <= {16'h0, diag_cnt_ff};
                default: s_rdata <= '0;
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end

    // Error causes detected this cycle
    always_comb begin
        err_set = '0;
        err_set[mch_pkg::ERR_DTR_OFF] = auto_mode && tx_req && state_ff == mch_pkg::ST_IDLE && !dtr_out; // R04
        err_set[mch_pkg::ERR_CTS_TMO] = state_ff == mch_pkg::ST_WAIT && tmr_ff == '0 && !cts_on; // R07
        err_set[mch_pkg::ERR_CTS_DROP] = auto_mode && state_ff == mch_pkg::ST_SEND && !cts_on; // R08
        err_set[mch_pkg::ERR_DSR_DROP] = auto_mode && dsr_fall; // R13
    end

    // Sticky errors; a new cause beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_ff <= '0;
        end else if (do_write && awaddr_ff == mch_pkg::ADDR_ERR && wstrb_ff[0]) begin
            err_ff <= (err_ff & ~wdata_ff[mch_pkg::ERR_W-1:0]) | err_set;
        end else begin
            err_ff <= err_ff | err_set;
        end
    end

    // Diagnostic log of DSR drop events, saturating
    always_ff @(posedge aclk) begin
        if (!aresetn)
            diag_cnt_ff <= '0;
        else if (err_set[mch_pkg::ERR_DSR_DROP] && diag_cnt_ff != 16'hffff)
            diag_cnt_ff <= diag_cnt_ff + 16'h0001; // R13
    end

    // Send handshake sequencer and its interval timer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= mch_pkg::ST_IDLE;
            tmr_ff <= '0;
        end else begin
            case (state_ff)
                mch_pkg::ST_IDLE: begin
                    if (tx_req && (!auto_mode || dtr_out)) begin // R03
                        state_ff <= auto_mode ? mch_pkg::ST_WAIT : mch_pkg::ST_SEND;
                        tmr_ff <= wait_cfg_ff; // R05 R19
                    end
                end
                mch_pkg::ST_WAIT: begin
                    if (dsr_fall || (tmr_ff == '0 && !cts_on) || !auto_mode)
                        state_ff <= mch_pkg::ST_IDLE; // R07 R13 R19
                    else if (tmr_ff == '0)
                        state_ff <= mch_pkg::ST_SEND; // R06
                    else
                        tmr_ff <= tmr_ff - 16'h0001;
                end
                mch_pkg::ST_SEND: begin
                    if (auto_mode && (dsr_fall || !cts_on)) begin
                        state_ff <= mch_pkg::ST_IDLE; // R08 R13
                    end else if (tx_last_done) begin
                        state_ff <= auto_mode ? mch_pkg::ST_HOLD : mch_pkg::ST_IDLE;
                        tmr_ff <= rtsoff_cfg_ff; // R09 R19
                    end
                end
                mch_pkg::ST_HOLD: begin
                    // CTS is not looked at here
                    if (tmr_ff == '0 || !auto_mode)
                        state_ff <= mch_pkg::ST_IDLE; // R09 R10
                    else
                        tmr_ff <= tmr_ff - 16'h0001;
                end
                default: state_ff <= mch_pkg::ST_IDLE;
            endcase
        end
    end

    // Line outputs: software levels only outside automatic mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dtr_out <= 1'b0; // R01
            rts_out <= 1'b0; // R01
            auto_q_ff <= 1'b0;
        end else begin
            auto_q_ff <= auto_mode;
            if (!auto_mode) begin
                dtr_out <= ctrl_ff[mch_pkg::CTRL_DTR];
                rts_out <= ctrl_ff[mch_pkg::CTRL_RTS];
            end else if (!auto_q_ff) begin
                dtr_out <= 1'b1; // R02 R14
                rts_out <= 1'b0; // R02
            end else begin
                dtr_out <= 1'b1; // R14
                // RTS follows sequencer; an abort lands in idle and drops it
                case (state_ff)
                    mch_pkg::ST_IDLE: rts_out <= tx_req && dtr_out; // R05
                    mch_pkg::ST_WAIT: rts_out <= !(dsr_fall || (tmr_ff == '0 && !cts_on)); // R19
                    mch_pkg::ST_SEND: rts_out <= !(dsr_fall || !cts_on); // R08 R13
                    mch_pkg::ST_HOLD: rts_out <= tmr_ff != '0; // R09 R10
                    default: rts_out <= 1'b0;
                endcase
            end
        end
    end

    // User-side strobes; near-full never touches a line output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_grant <= 1'b0;
            tx_fail <= 1'b0;
            rx_enable <= 1'b0;
            rx_abort <= 1'b0;
        end else begin
            tx_grant <= (auto_mode && state_ff == mch_pkg::ST_WAIT && tmr_ff == '0 && cts_on && !dsr_fall) ||
                (state_ff == mch_pkg::ST_SEND && !tx_last_done &&
                !(auto_mode && (dsr_fall || !cts_on))) ||
                (state_ff == mch_pkg::ST_IDLE && tx_req && !auto_mode); // R06
            tx_fail <= err_set[mch_pkg::ERR_DTR_OFF] || err_set[mch_pkg::ERR_CTS_TMO] ||
                err_set[mch_pkg::ERR_CTS_DROP] ||
                (auto_mode && dsr_fall && (state_ff == mch_pkg::ST_WAIT || state_ff == mch_pkg::ST_SEND)); // R04 R08
            // Near-full left out on purpose: no back-pressure toward the partner
            rx_enable <= !auto_mode || (dtr_out && sync2_ff.dsr); // R03 R11 R12
            rx_abort <= auto_mode && dsr_fall && rx_enable; // R13
        end
    end

    // Checks on the handshake behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_auto_entry_lines: assert property ($rose(auto_mode) |=> dtr_out && !rts_out) // R02
        else $error("auto entry did not set dtr on and rts off");
    a_dtr_off_refuse: assert property (auto_mode && state_ff == mch_pkg::ST_IDLE
        && tx_req && !dtr_out |=> tx_fail && state_ff == mch_pkg::ST_IDLE) // R04
        else $error("send with dtr off not refused");
    a_wait_loads_rts: assert property (auto_mode && auto_q_ff && state_ff == mch_pkg::ST_IDLE
        && tx_req && dtr_out |=> rts_out && tmr_ff == $past(wait_cfg_ff)) // R05
        else $error("request did not raise rts with waiting time");
    a_grant_needs_cts: assert property (auto_mode && tx_grant |-> $past(cts_on)) // R06
        else $error("grant without cts");
    a_cts_timeout_err: assert property (state_ff == mch_pkg::ST_WAIT && tmr_ff == '0 && !cts_on
        |=> err_ff[mch_pkg::ERR_CTS_TMO] && tx_fail && state_ff == mch_pkg::ST_IDLE) // R07
        else $error("cts timeout not aborted");
    a_cts_drop_abort: assert property (auto_mode && state_ff == mch_pkg::ST_SEND && !cts_on
        |=> state_ff == mch_pkg::ST_IDLE && !tx_grant && err_ff[mch_pkg::ERR_CTS_DROP]) // R08
        else $error("cts drop did not abort send");
    a_hold_rts_on: assert property (auto_mode && state_ff == mch_pkg::ST_HOLD && tmr_ff != '0
        && auto_q_ff |=> rts_out) // R09
        else $error("rts dropped before hold ended");
    a_hold_ends_free: assert property (auto_mode && auto_q_ff && state_ff == mch_pkg::ST_HOLD
        && tmr_ff == '0 |=> !rts_out ##1 state_ff == mch_pkg::ST_IDLE) // R10
        else $error("rts release waited on cts");
    a_rx_needs_dsr: assert property (auto_mode && rx_enable |-> $past(sync2_ff.dsr)) // R11
        else $error("receive enabled without dsr");
    a_dsr_drop_log: assert property (auto_mode && dsr_fall && diag_cnt_ff != 16'hffff
        |=> err_ff[mch_pkg::ERR_DSR_DROP] && diag_cnt_ff == $past(diag_cnt_ff) + 16'h0001) // R13
        else $error("dsr drop not logged");
    a_auto_ignores_sw: assert property (auto_mode && auto_q_ff |=> dtr_out) // R14
        else $error("software changed dtr in auto mode");
endmodule
`default_nettype wire

// ### tb/mch_partner.sv
// Partner model: the modem side of the handshake lines.
// Assumes the bench steers partner readiness and DSR on aclk edges.
`timescale 1ns/1ps
`default_nettype none
module mch_partner (
    // Clock
    input wire logic aclk,
    // Line from the device
    input wire logic rts,
    // Bench controls
    input wire logic dsr_on,
    input wire logic cts_able,
    input wire logic [7:0] cts_dly,
    // Lines to the device
    output var mch_pkg::mch_line_in_s line_in
);
    logic [7:0] cnt;
    // Known levels before the first edge reach the synchroniser
    initial begin
        cnt = 8'h00;
        line_in = '0;
    end
    // CTS answers RTS after a delay, saturating so CTS never wraps off
    always @(posedge aclk) begin
        cnt <= (rts && cts_able) ? cnt + {7'h00, cnt != 8'hff} : 8'h00;
        line_in.cts <= rts && cts_able && (cnt >= cts_dly);
        line_in.dsr <= dsr_on;
        line_in.dcd <= dsr_on;
        line_in.ri <= 1'b0;
    end
endmodule
`default_nettype wire

// ### tb/mch_top_tb.sv
// Self-checking bench for the modem-control handshake block.
// Assumes the partner model and AXI4-Lite access to the map.
`timescale 1ns/1ps
`default_nettype none
module mch_top_tb;
    localparam int WAITC = 12;
    localparam int OFFC = 6;
    logic aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
    logic [7:0] s_awaddr, s_araddr, cts_dly;
    logic [31:0] s_wdata, rd;
    logic [1:0] rr;
    logic tx_req, tx_last_done, rx_near_full, dsr_on, cts_able;
    wire logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, dtr_out, rts_out;
    wire logic tx_grant, tx_fail, rx_enable, rx_abort;
    wire logic [1:0] s_bresp, s_rresp;
    wire logic [31:0] s_rdata;
    wire mch_pkg::mch_line_in_s line_in;
    int fail_count, checks_done, cyc;

    mch_top mch_top_inst (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .line_in(line_in), .dtr_out(dtr_out), .rts_out(rts_out),
        .tx_req(tx_req), .tx_last_done(tx_last_done), .tx_grant(tx_grant), .tx_fail(tx_fail),
        .rx_near_full(rx_near_full), .rx_enable(rx_enable), .rx_abort(rx_abort));
    mch_partner mch_partner_inst (.aclk(aclk), .rts(rts_out), .dsr_on(dsr_on), .cts_able(cts_able),
        .cts_dly(cts_dly), .line_in(line_in));

    // 200 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Shared comparison and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic report_and_stop;
        $display("mismatches=%0d comparisons=%0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            report_and_stop();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // Bus master: each channel held until its own handshake edge; bready and rready stay high
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            n++;
        end while (!s_bvalid && n < 300);
        tmo(n);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            n++;
        end while (!s_rvalid && n < 300);
        tmo(n);
        rd = s_rdata;
        rr = s_rresp;
    endtask

    // Bounded waits on design outputs
    function automatic logic sel(input int w);
        case (w)
            0: sel = tx_grant;
            1: sel = tx_fail;
            2: sel = !rts_out;
            default: sel = rx_abort;
        endcase
    endfunction
    task automatic wait_sig(input int w, output int c);
        c = 0;
        while (!sel(w) && c < 300) begin
            @(posedge aclk);
            c++;
        end
        tmo(c);
    endtask
    task automatic req;
        tx_req <= 1'b1;
        @(posedge aclk);
        tx_req <= 1'b0;
        @(posedge aclk);
        chk(rts_out, 1);
    endtask

    // Scenarios
    task automatic t_regs;
        axi_rd(mch_pkg::ADDR_CTRL);
        chk(rd, 0);
        axi_rd(mch_pkg::ADDR_RTSOFF);
        chk(rd[15:0], mch_pkg::RTSOFF_RST);
        axi_rd(8'h18);
        chk(rr, mch_pkg::RESP_DECERR);
    endtask
    // Request raised just after the edge that turns on automatic mode, while DTR is still off
    task automatic t_dtr_off;
        fork
            axi_wr(mch_pkg::ADDR_CTRL, 32'h1);
            begin
                tick(2);
                tx_req <= 1'b1;
                tick(1);
                tx_req <= 1'b0;
            end
        join
        tick(1);
        chk({tx_fail, rts_out, rx_enable}, 3'b100);
        axi_rd(mch_pkg::ADDR_ERR);
        chk(rd[3:0], 4'h1);
        axi_wr(mch_pkg::ADDR_ERR, 32'hf);
    endtask
    task automatic t_auto;
        axi_wr(mch_pkg::ADDR_CTRL, 32'h6);
        tick(2);
        chk({dtr_out, rts_out}, 2'b11);
        axi_wr(mch_pkg::ADDR_CTRL, 32'h1);
        tick(2);
        chk({dtr_out, rts_out}, 2'b10);
        // Software line bits must be ignored while automatic
        axi_wr(mch_pkg::ADDR_CTRL, 32'h7);
        rx_near_full <= 1'b1;
        tick(4);
        chk({dtr_out, rts_out, rx_enable}, 3'b101);
        rx_near_full <= 1'b0;
        axi_wr(mch_pkg::ADDR_WAIT, WAITC);
        axi_wr(mch_pkg::ADDR_RTSOFF, OFFC);
        axi_rd(mch_pkg::ADDR_LINE);
        chk(rd[11:0], 12'h107);
    endtask
    task automatic t_good;
        cts_able <= 1'b1;
        req();
        wait_sig(0, cyc);
        chk(cyc >= WAITC && cyc <= WAITC + 3, 1);
        tx_last_done <= 1'b1;
        @(posedge aclk);
        tx_last_done <= 1'b0;
        wait_sig(2, cyc);
        chk(cyc >= OFFC && cyc <= OFFC + 3, 1);
        chk(line_in.cts, 1);
        tick(2);
    endtask
    task automatic t_cts_tmo;
        cts_able <= 1'b0;
        req();
        wait_sig(1, cyc);
        chk(cyc >= WAITC - 1 && cyc <= WAITC + 3, 1);
        tick(1);
        chk({tx_grant, rts_out}, 0);
        axi_rd(mch_pkg::ADDR_ERR);
        chk(rd[3:0], 4'h2);
        axi_wr(mch_pkg::ADDR_ERR, 32'hf);
    endtask
    task automatic t_cts_drop;
        cts_able <= 1'b1;
        req();
        wait_sig(0, cyc);
        cts_able <= 1'b0;
        wait_sig(1, cyc);
        chk(cyc <= 8, 1);
        tick(1);
        chk({tx_grant, rts_out}, 0);
        axi_rd(mch_pkg::ADDR_ERR);
        chk(rd[3:0], 4'h4);
        axi_wr(mch_pkg::ADDR_ERR, 32'hf);
    endtask
    task automatic t_dsr;
        cts_able <= 1'b1;
        req();
        wait_sig(0, cyc);
        dsr_on <= 1'b0;
        wait_sig(3, cyc);
        chk(cyc <= 8, 1);
        tick(2);
        chk({rx_enable, tx_grant, rts_out}, 0);
        axi_rd(mch_pkg::ADDR_ERR);
        chk(rd[3:0], 4'h8);
        axi_rd(mch_pkg::ADDR_DIAG);
        chk(rd, 1);
        dsr_on <= 1'b1;
        tick(6);
        chk(rx_enable, 1);
    endtask

    // Main sequence; every input known at time zero
    initial begin
        fail_count = 0;
        checks_done = 0;
        aresetn = 1'b0;
        {s_awvalid, s_wvalid, s_arvalid} = '0;
        {s_bready, s_rready} = 2'b11;
        {s_awaddr, s_araddr, s_wdata} = '0;
        {tx_req, tx_last_done, rx_near_full, cts_able} = '0;
        dsr_on = 1'b1;
        cts_dly = 8'h02;
        repeat (3) @(posedge aclk);
        chk({dtr_out, rts_out}, 0);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_dtr_off();
        t_auto();
        t_good();
        t_cts_tmo();
        t_cts_drop();
        t_dsr();
        report_and_stop();
    end
endmodule
`default_nettype wire
